// ===== inc/lesc_pkg.sv
// Constants and encodings for the lane enable and snoop control block
`default_nettype none

package lesc_pkg;

  // ----------------------------------------------------------------------
  // Register port geometry
  // ----------------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          LANES           = 4;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0]  LINK_CTRL_OFS   = 8'h0A;
  localparam logic [7:0]  EQ_CTRL_OFS     = 8'h10;
  localparam logic [7:0]  CAPTURE_OFS     = 8'h12;
  localparam logic [7:0]  LANE_CTRL_OFS   = 8'h13;

  // ----------------------------------------------------------------------
  // Field positions, widths, masks and reset values
  // ----------------------------------------------------------------------
  localparam int          SNOOP_OFF_BIT   = 7;
  localparam int          RO_ZERO_BIT     = 6;
  localparam int          LANE_OFF_LSB    = 0;
  localparam int          CTL_SEL_LSB     = 0;
  localparam int          CTL_SEL_HI_BIT  = 1;
  localparam int          LC_W            = 5;
  localparam int          PS_W            = 2;
  localparam int          PS_LSB          = 5;
  localparam int          EQ_W            = 4;
  localparam logic [7:0]  LANE_CTRL_RST   = 8'h00;
  localparam logic [7:0]  LANE_CTRL_WMASK = 8'hBF;
  localparam logic [7:0]  EQ_CTRL_RST     = 8'h00;
  localparam logic [4:0]  LANE_COUNT_RST  = 5'h00;
  localparam logic [1:0]  POWER_STATE_RST = 2'h0;
  localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;

  // ----------------------------------------------------------------------
  // Control select encoding
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CTL_SHUTDOWN = 2'h0,
    CTL_IDLE     = 2'h1,
    CTL_LINK_ON  = 2'h2,
    CTL_RESERVED = 2'h3
  } lesc_control_select_e;

  localparam lesc_control_select_e CTL_SEL_RST    = CTL_IDLE;

  // ----------------------------------------------------------------------
  // Monitored link configuration addresses and values
  // ----------------------------------------------------------------------
  localparam int          AUX_ADDR_W      = 20;
  localparam logic [19:0] AUX_LANE_COUNT  = 20'h00101;
  localparam logic [19:0] AUX_POWER_STATE = 20'h00600;
  localparam logic [1:0]  POWER_ACTIVE    = 2'h1;

endpackage : lesc_pkg

`default_nettype wire

// ===== verilog/lesc_lane_gate.sv
// Power decision for one main-link lane
`timescale 1ns/1ps
`default_nettype none

module lesc_lane_gate #(
  parameter int IDX = 0
) (
  // Link level qualifiers
  input  wire logic       link_on,
  input  wire logic       hotplug,
  // Source selection and software disable
  input  wire logic       snoop_off,
  input  wire logic       lane_off,
  // Captured link configuration
  input  wire logic [4:0] lane_count,
  input  wire logic [1:0] power_state,
  // Decision
  output wire logic       lane_on
);

  logic snoop_en;
  logic src_en;

  // Lane used by captured count while the link is in active power
  assign snoop_en = (lane_count > 5'(IDX))
                    && (power_state == lesc_pkg::POWER_ACTIVE);
  // Pick captured decision or software bit; 0 enables, 1 disables
  assign src_en   = snoop_off ? ~lane_off : snoop_en;
  // All three conditions must agree before the lane is powered
  assign lane_on  = link_on & hotplug & src_en;

endmodule : lesc_lane_gate

`default_nettype wire

// ===== verilog/lesc_top.sv
// Lane enable and AUX snoop control with its register port
//
// Overview of operation
// - Bit 7 of the lane control register turns AUX monitoring off when 1.
// - With monitoring off, bits 3..0 switch lanes 3..0 individually.
// - With monitoring on, the disable bits are stored but do not move lanes.
// - A disable bit of 0 enables its lane (reset) and 1 disables it.
// - Register lane_power_control resets to zero, bit 6 reads zero, bits 5:4 are storage.
// - AUX writes are only observed while the monitor enable pin is low.
// - Hot-plug high enables link function, low disables it to save power.
// - Hot-plug comes from the strap pin when config select is 0, else other.
// - In strap mode the equalization code comes from the two strap pins.
// - A lane count written to 0x00101 enables only the counted lanes.
// - A power state written to 0x00600 turns the lanes on or off.
// - Captured count and power state clear when control select bit 1 falls.
// - Control select is 00 shutdown, 01 idle (reset), 10 on, 11 reserved.
`timescale 1ns/1ps
`default_nettype none

module lesc_top #(
  parameter int LANES  = lesc_pkg::LANES,
  parameter int ADDR_W = lesc_pkg::ADDR_W,
  parameter int DATA_W = lesc_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output var  logic [DATA_W-1:0]   reg_rdata,
  output var  logic                reg_rvalid,
  // Observed AUX write transactions
  input  wire logic                aux_wr,
  input  wire logic [19:0]         aux_addr,
  input  wire logic [7:0]          aux_data,
  // Configuration pins
  input  wire logic                monitor_enable_n,
  input  wire logic                cfg_serial,
  input  wire logic                hotplug_in,
  input  wire logic                hotplug_in_alt,
  input  wire logic                eq_strap_low,
  input  wire logic                eq_strap_high,
  // Lane and link control
  output var  logic [LANES-1:0]    lane_active,
  output var  logic                link_enabled,
  output var  logic                link_shutdown,
  output var  logic [3:0]          eq_code
);

  // ----------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]              lane_ctrl;
    lesc_pkg::lesc_control_select_e  ctl_sel;
    logic [7:0]              eq_ctrl;
    logic [4:0]              lane_count;
    logic [1:0]              power_state;
    logic                    hotplug;
    logic [LANES-1:0]        lane_active;
    logic                    link_on;
    logic                    shutdown;
    logic [3:0]              eq_code;
    logic [DATA_W-1:0]       rdata;
    logic                    rvalid;
  } lesc_state_s;

  lesc_state_s cur_reg;
  lesc_state_s cur_next;

  logic [LANES-1:0] lane_on_w;
  logic             snoop_off_w;
  logic             snoop_active_w;
  logic             link_on_w;

  // ----------------------------------------------------------------------
  // Monitoring source and link qualifiers
  // ----------------------------------------------------------------------

  // Monitoring off by register bit or by the pin held high
  assign snoop_off_w    = cur_reg.lane_ctrl[lesc_pkg::SNOOP_OFF_BIT]
                          | monitor_enable_n;
  assign snoop_active_w = ~snoop_off_w;
  // Only the link-on code powers the main link
  assign link_on_w      = (cur_reg.ctl_sel == lesc_pkg::CTL_LINK_ON);

  // ----------------------------------------------------------------------
  // Per-lane decision
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++)
    begin : g_lane
      lesc_lane_gate #(
        .IDX         (gi)
      ) u_gate (
        .link_on     (link_on_w),
        .hotplug     (cur_reg.hotplug),
        .snoop_off   (snoop_off_w),
        .lane_off    (cur_reg.lane_ctrl[lesc_pkg::LANE_OFF_LSB + gi]),
        .lane_count  (cur_reg.lane_count),
        .power_state (cur_reg.power_state),
        .lane_on     (lane_on_w[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------

  // Register writes, capture, clear and output staging
  always_comb
  begin
    cur_next        = cur_reg;
    cur_next.rvalid = 1'b0;

    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        lesc_pkg::LANE_CTRL_OFS:
        begin
          // Bit 6 never stores; disable bits always store
          cur_next.lane_ctrl = reg_wdata
                               & lesc_pkg::LANE_CTRL_WMASK;
        end
        lesc_pkg::LINK_CTRL_OFS:
        begin
          cur_next.ctl_sel = lesc_pkg::lesc_control_select_e'(
            reg_wdata[lesc_pkg::CTL_SEL_LSB +: 2]);
        end
        lesc_pkg::EQ_CTRL_OFS:
        begin
          cur_next.eq_ctrl = reg_wdata;
        end
        default:
        begin
          cur_next.eq_ctrl = cur_reg.eq_ctrl;               // Unmapped: ignored
        end
      endcase
    end

    // Captured values clear when control select bit 1 falls
    if (cur_reg.ctl_sel[lesc_pkg::CTL_SEL_HI_BIT]
        && !cur_next.ctl_sel[lesc_pkg::CTL_SEL_HI_BIT])
    begin
      cur_next.lane_count  = lesc_pkg::LANE_COUNT_RST;
      cur_next.power_state = lesc_pkg::POWER_STATE_RST;
    end

    // AUX capture; placed after the clear so a capture wins
    if (aux_wr && snoop_active_w)
    begin
      if (aux_addr == lesc_pkg::AUX_LANE_COUNT)
      begin
        cur_next.lane_count = aux_data[lesc_pkg::LC_W-1:0];
      end
      if (aux_addr == lesc_pkg::AUX_POWER_STATE)
      begin
        cur_next.power_state = aux_data[lesc_pkg::PS_W-1:0];
      end
    end

    // Hot-plug pin follows configuration mode
    cur_next.hotplug = cfg_serial ? hotplug_in_alt : hotplug_in;

    // Equalization from straps in strap mode, else from register
    if (!cfg_serial)
    begin
      cur_next.eq_code = {2'b00, eq_strap_high, eq_strap_low};
    end
    else
    begin
      cur_next.eq_code = cur_reg.eq_ctrl[lesc_pkg::EQ_W-1:0];
    end

    // Lane and link outputs
    cur_next.lane_active = lane_on_w;
    cur_next.link_on     = link_on_w & cur_reg.hotplug;
    cur_next.shutdown    = (cur_reg.ctl_sel == lesc_pkg::CTL_SHUTDOWN);

    // Register reads, answered one edge later
    if (reg_rd)
    begin
      cur_next.rvalid = 1'b1;
      unique case (reg_addr)
        lesc_pkg::LANE_CTRL_OFS:
        begin
          cur_next.rdata = cur_reg.lane_ctrl;
        end
        lesc_pkg::CAPTURE_OFS:
        begin
          cur_next.rdata = {1'b0, cur_reg.power_state, cur_reg.lane_count};
        end
        lesc_pkg::LINK_CTRL_OFS:
        begin
          cur_next.rdata = {6'h00, cur_reg.ctl_sel};
        end
        lesc_pkg::EQ_CTRL_OFS:
        begin
          cur_next.rdata = cfg_serial ? cur_reg.eq_ctrl
                                      : {4'h0, cur_reg.eq_code};
        end
        default:
        begin
          cur_next.rdata = lesc_pkg::UNMAPPED_DATA;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Synchronous reset to documented defaults
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cur_reg             <= '0;
      cur_reg.lane_ctrl   <= lesc_pkg::LANE_CTRL_RST;
      cur_reg.ctl_sel     <= lesc_pkg::CTL_SEL_RST;
      cur_reg.eq_ctrl     <= lesc_pkg::EQ_CTRL_RST;
      cur_reg.lane_count  <= lesc_pkg::LANE_COUNT_RST;
      cur_reg.power_state <= lesc_pkg::POWER_STATE_RST;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // All outputs are state flops
  assign reg_rdata     = cur_reg.rdata;
  assign reg_rvalid    = cur_reg.rvalid;
  assign lane_active   = cur_reg.lane_active;
  assign link_enabled  = cur_reg.link_on;
  assign link_shutdown = cur_reg.shutdown;
  assign eq_code       = cur_reg.eq_code;

endmodule : lesc_top

`default_nettype wire

// ===== dv/lesc_top_sva.sv
// Port-level checker for the lane enable and snoop control block
`timescale 1ns/1ps
`default_nettype none

module lesc_top_sva #(
  parameter int LANES = lesc_pkg::LANES
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_rdata,
  input  wire logic             reg_rvalid,
  // Pins
  input  wire logic             cfg_serial,
  input  wire logic             hotplug_in,
  input  wire logic             hotplug_in_alt,
  input  wire logic             eq_strap_low,
  input  wire logic             eq_strap_high,
  // Lane and link control
  input  wire logic [LANES-1:0] lane_active,
  input  wire logic             link_enabled,
  input  wire logic             link_shutdown,
  input  wire logic [3:0]       eq_code
);
  // ------------------------------------------------------------
  // Hot-plug level of the selected pin
  // ------------------------------------------------------------
  logic hp;
  assign hp = cfg_serial ? hotplug_in_alt : hotplug_in;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read got no answer");
  rd_quiet_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("answer without a read");
  bit6_zero_a: assert property (reg_rvalid &&
    $past(reg_addr) == 8'h13 |-> !reg_rdata[6])
    else $error("bit 6 read as one");
  rdata_hold_a: assert property (!reg_rvalid &&
    $past(rst_n) |-> $stable(reg_rdata))
    else $error("read data moved without answer");
  lane_gate_a: assert property (lane_active != '0 |-> link_enabled)
    else $error("lane on with link off");
  shut_quiet_a: assert property (link_shutdown |->
    !link_enabled && lane_active == '0)
    else $error("activity in shutdown");
  hp_low_a: assert property (!hp [*3] |->
    !link_enabled && lane_active == '0)
    else $error("link on without hot-plug");
  link_cause_a: assert property (link_enabled |-> $past(hp, 2))
    else $error("link on from wrong hot-plug pin");
  eq_strap_a: assert property (!cfg_serial |=> eq_code ==
    {2'b00, $past(eq_strap_high), $past(eq_strap_low)})
    else $error("eq code not from straps");

  // Main scenarios reached
  cover property (lane_active == 4'hF);
  cover property (link_shutdown);
  cover property (reg_rvalid && reg_rdata[7]);
endmodule : lesc_top_sva

bind lesc_top lesc_top_sva #(.LANES(LANES)) i_lesc_top_sva (
  .core_clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid,
  .cfg_serial, .hotplug_in, .hotplug_in_alt, .eq_strap_low,
  .eq_strap_high, .lane_active, .link_enabled, .link_shutdown, .eq_code
);

`default_nettype wire

// ===== dv/lesc_aux_model.sv
// Source and sink side model issuing observed AUX writes
`timescale 1ns/1ps
`default_nettype none

module lesc_aux_model (
  // Clock
  input  wire logic        core_clk,
  // Observed AUX write
  output var  logic        aux_wr,
  output var  logic [19:0] aux_addr,
  output var  logic [7:0]  aux_data
);
  // Idle bus starts away from any real address
  initial
  begin
    aux_wr   = 1'b0;
    aux_addr = 20'hFFFFF;
    aux_data = 8'hFF;
  end

  // One write after an optional idle gap; idle lines inverted after
  task automatic send(input logic [19:0] a, input logic [7:0] d,
                      input int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    aux_wr   <= 1'b1;
    aux_addr <= a;
    aux_data <= d;
    @(posedge core_clk);
    aux_wr   <= 1'b0;
    aux_addr <= ~a;
    aux_data <= ~d;
  endtask : send
endmodule : lesc_aux_model

`default_nettype wire

// ===== dv/lesc_top_test.sv
// Self-checking testbench for the lane enable and snoop control block
`timescale 1ns/1ps
`default_nettype none

module lesc_top_test;
  logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, reg_rvalid;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic aux_wr, link_enabled, link_shutdown;
  logic [19:0] aux_addr;
  logic [7:0] aux_data;
  logic monitor_enable_n = 0, cfg_serial = 0, hotplug_in = 0;
  logic hotplug_in_alt = 0, eq_strap_low = 0, eq_strap_high = 0;
  logic [3:0] lane_active, eq_code;
  int n_errors = 0, checks_done = 0, cycles = 0;

  // Clock and design
  always #10 core_clk = ~core_clk;
  lesc_top i_lesc_top (.core_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .aux_wr, .aux_addr,
    .aux_data, .monitor_enable_n, .cfg_serial, .hotplug_in,
    .hotplug_in_alt, .eq_strap_low, .eq_strap_high, .lane_active,
    .link_enabled, .link_shutdown, .eq_code);
  lesc_aux_model i_lesc_aux_model (.core_clk, .aux_wr, .aux_addr,
    .aux_data);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic results;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    chk({7'h00, reg_rvalid}, 8'h01);
  endtask : rd
  // Status byte {00, shutdown, enabled, lanes} after outputs settle
  task automatic st(input logic [7:0] e);
    repeat (4) @(posedge core_clk);
    #1 chk({2'b00, link_shutdown, link_enabled, lane_active}, e);
  endtask : st
  task automatic aux(input logic [19:0] a, input logic [7:0] d);
    i_lesc_aux_model.send(a, d, 0);
  endtask : aux

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_snoop;
    @(posedge core_clk) hotplug_in <= 1'b1;
    wr(8'h0A, 8'h02);
    i_lesc_aux_model.send(20'h00600, 8'h01, 3);
    aux(20'h00101, 8'h02);
    st(8'h13);
    wr(8'h13, 8'h0F);
    st(8'h13);
    aux(20'h00101, 8'h04);
    st(8'h1F);
    aux(20'h00600, 8'h02);
    st(8'h10);
    aux(20'h00600, 8'h01);
    rd(8'h12, 8'h24);
  endtask : t_snoop
  task automatic t_soft;
    @(posedge core_clk) monitor_enable_n <= 1'b1;
    st(8'h10);
    aux(20'h00101, 8'h01);
    rd(8'h12, 8'h24);
    @(posedge core_clk) monitor_enable_n <= 1'b0;
    st(8'h1F);
    wr(8'h13, 8'h85);
    st(8'h1A);
    aux(20'h00101, 8'h01);
    rd(8'h12, 8'h24);
    wr(8'h13, 8'hF0);
    rd(8'h13, 8'hB0);
    st(8'h1F);
    wr(8'h13, 8'h00);
  endtask : t_soft
  task automatic t_pins;
    @(posedge core_clk) hotplug_in <= 1'b0;
    st(8'h00);
    @(posedge core_clk) cfg_serial <= 1'b1;
    hotplug_in_alt <= 1'b1;
    st(8'h1F);
    rd(8'h10, 8'h00);
    @(posedge core_clk) cfg_serial <= 1'b0;
    st(8'h00);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk) {eq_strap_high, eq_strap_low} <= 2'(i);
      st(8'h00);
      chk({4'h0, eq_code}, 8'(i));
    end
    wr(8'h10, 8'h0C);
    @(posedge core_clk) cfg_serial <= 1'b1;
    st(8'h1F);
    chk({4'h0, eq_code}, 8'h0C);
    rd(8'h10, 8'h0C);
  endtask : t_pins
  task automatic t_clear;
    wr(8'h0A, 8'h00);
    rd(8'h12, 8'h00);
    // Read-only capture byte and unmapped offsets ignore writes
    wr(8'h12, 8'hFF);
    wr(8'hFF, 8'hFF);
    rd(8'h12, 8'h00);
    rd(8'h13, 8'h00);
    rd(8'h0A, 8'h00);
    st(8'h20);
    wr(8'h0A, 8'h03);
    st(8'h00);
    wr(8'h0A, 8'h02);
    st(8'h10);
  endtask : t_clear

  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      results;
    end
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h13, 8'h00);
    rd(8'h0A, 8'h01);
    rd(8'hFF, 8'h00);
    st(8'h00);
    t_snoop;
    t_soft;
    t_pins;
    t_clear;
    results;
  end
endmodule : lesc_top_test

`default_nettype wire
